// ===== hw/smsp_port.sv
// serial peripheral port: master or slave, full duplex, flags
//
// Contract
// - data moves both ways at once, as master or as selected slave.
// - master rate and slave clock scale from 24 Mbps/12 MHz at 48 MHz; the code divides SYS_CLK_MHZ by 2 * MASTER_MBPS, never checks the slave clock.
// - status shows transfer-complete, write-collision and mode-fault flags.
// - outgoing data waits in a holding register with a holding-full flag.
// - a read-only busy flag stands while the shift engine works.
// - master drives MOSI and samples MISO, slave the reverse.
// - serial clock is output as master and input as slave.
// - with the enable bit clear the pins fall back to general I/O.
// - the enable bit is zero after reset.
// - select ignored if disabled, master driving select, or ignore set.
// - a slave with ignore clear works only while its select is low.
// - master, ignore clear, select low: turn slave, set done, clear enable.
// - two peers idle as masters; the initiator forces the other to slave.
`timescale 1ns/1ps
module smsp_port
    import smsp_pkg::*;
#(
    parameter int BITS = DATA_BITS
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  ctl_wdata,
    input  wire logic        ctl_we,
    output logic      [7:0]  serial_control_reg,
    input  wire logic [7:0]  tx_wdata,
    input  wire logic        tx_we,
    output logic      [7:0]  rx_data,
    output logic      [7:0]  serial_status_reg,
    input  wire logic        status_clr,
    input  wire logic [7:0]  status_clr_mask,
    input  wire logic        select_pin_is_output,
    input  wire logic        sclk_i,
    input  wire logic        mosi_i,
    input  wire logic        miso_i,
    input  wire logic        slave_select_n,
    output smsp_pins_t       pins
);
    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  tx_holding_reg;
        logic        tx_holding_full;
        logic [7:0]  shift;
        logic [7:0]  rx;
        logic [3:0]  bit_cnt;
        logic [7:0]  div_cnt;
        logic        sclk;
        logic        sclk_prev;
        logic        out_bit;
        logic        is_master_xfer;
        smsp_state_t state;
        smsp_flags_t flags;
    } smsp_core_t;

    smsp_core_t s_reg;
    smsp_core_t s_next;
    logic [3:0] pin_sync;
    logic       sclk_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ssn_s;
    logic       enabled;
    logic       master;
    logic       ignore_sel;
    logic       sel_used;
    logic       selected;
    logic       rise;
    logic       fall;

    initial begin
        if (BITS != DATA_BITS) begin
            $error("smsp_port supports eight-bit frames only");
        end
        // miso is picked up one half period late to cover the synchroniser
        if (HALF_CYCLES < 2) begin
            $error("smsp_port needs two system cycles per clock half");
        end
    end

    smsp_sync #(.WIDTH(4)) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in ({sclk_i, mosi_i, miso_i, slave_select_n}),
        .sync_out (pin_sync)
    );
    assign {sclk_s, mosi_s, miso_s, ssn_s} = pin_sync;

    assign enabled    = s_reg.ctl[CTL_ENABLE_POS];
    assign master     = s_reg.ctl[CTL_MASTER_POS];
    assign ignore_sel = s_reg.ctl[CTL_SEL_IGNORE_POS];
    // select pin only counts when none of the three ignore cases holds
    assign sel_used   = enabled && !ignore_sel &&
                        !(master && select_pin_is_output);
    assign selected   = sel_used && !ssn_s;
    assign rise = sclk_s && !s_reg.sclk_prev;
    assign fall = !sclk_s && s_reg.sclk_prev;

    always_comb begin
        s_next = s_reg;
        s_next.sclk_prev = sclk_s;
        if (ctl_we) begin
            s_next.ctl = ctl_wdata;
        end
        if (status_clr) begin
            if (status_clr_mask[ST_DONE_POS]) s_next.flags.done = 1'b0;
            if (status_clr_mask[ST_COLLIDE_POS]) s_next.flags.collide = 1'b0;
            if (status_clr_mask[ST_FAULT_POS]) s_next.flags.fault = 1'b0;
        end
        if (tx_we) begin
            if (s_reg.tx_holding_full && s_reg.state != SMSP_IDLE) begin
                s_next.flags.collide = 1'b1;
            end else begin
                s_next.tx_holding_reg  = tx_wdata;
                s_next.tx_holding_full = 1'b1;
            end
        end
        // a low select on a master turns it into a disabled slave
        if (enabled && master && sel_used && !ssn_s) begin
            s_next.ctl[CTL_MASTER_POS] = 1'b0;
            s_next.ctl[CTL_ENABLE_POS] = 1'b0;
            s_next.flags.done  = 1'b1;
            s_next.flags.fault = 1'b1;
            s_next.state = SMSP_IDLE;
            s_next.sclk  = 1'b0;
        end else begin
            case (s_reg.state)
                SMSP_IDLE: begin
                    s_next.sclk = 1'b0;
                    if (enabled && master && s_reg.tx_holding_full) begin
                        s_next.shift = s_reg.tx_holding_reg;
                        s_next.out_bit = s_reg.tx_holding_reg[7];
                        // a write in this very cycle stays held
                        s_next.tx_holding_full = tx_we;
                        s_next.bit_cnt = 4'h0;
                        s_next.div_cnt = 8'h00;
                        s_next.is_master_xfer = 1'b1;
                        s_next.state = SMSP_SHIFT;
                    end else if (enabled && !master && selected) begin
                        // slave preloads whatever is held, else zeros
                        s_next.shift = s_reg.tx_holding_full ?
                            s_reg.tx_holding_reg : 8'h00;
                        s_next.out_bit = s_next.shift[7];
                        s_next.tx_holding_full = tx_we;
                        s_next.bit_cnt = 4'h0;
                        s_next.is_master_xfer = 1'b0;
                        s_next.state = SMSP_SHIFT;
                    end
                end
                SMSP_SHIFT: begin
                    if (s_reg.is_master_xfer) begin
                        // master: divider paces the clock it drives
                        if (s_reg.div_cnt == 8'(HALF_CYCLES - 1)) begin
                            s_next.div_cnt = 8'h00;
                            s_next.sclk = !s_reg.sclk;
                            if (!s_reg.sclk) begin
                                s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                            end else begin
                                // miso_s lags two cycles: it now shows
                                // the line as it stood at the rise
                                s_next.shift = {s_reg.shift[6:0], miso_s};
                                s_next.out_bit = s_reg.shift[6];
                                if (s_reg.bit_cnt == 4'h8) begin
                                    s_next.state = SMSP_LAST;
                                end
                            end
                        end else begin
                            s_next.div_cnt = s_reg.div_cnt + 8'h01;
                        end
                    end else if (!selected) begin
                        s_next.state = SMSP_IDLE;
                    end else if (rise) begin
                        s_next.shift = {s_reg.shift[6:0], mosi_s};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                        if (s_reg.bit_cnt == 4'h7) begin
                            s_next.state = SMSP_LAST;
                        end
                    end else if (fall) begin
                        s_next.out_bit = s_reg.shift[7];
                    end
                end
                SMSP_LAST: begin
                    s_next.rx = s_reg.shift;
                    s_next.flags.done = 1'b1;
                    s_next.sclk = 1'b0;
                    s_next.state = SMSP_IDLE;
                end
                default: begin
                    s_next.state = SMSP_IDLE;
                end
            endcase
        end
        s_next.flags.hold_full = s_next.tx_holding_full;
        s_next.flags.busy = (s_next.state != SMSP_IDLE);
        if (!enabled && s_next.state == SMSP_IDLE) begin
            s_next.sclk = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.ctl <= CTL_RESET;
            s_reg.state <= SMSP_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin directions and visible registers

    always_comb begin
        pins.sclk_o  = s_reg.sclk;
        pins.sclk_oe = enabled && master;
        pins.mosi_o  = s_reg.out_bit;
        pins.mosi_oe = enabled && master;
        pins.miso_o  = s_reg.out_bit;
        // a slave drives miso only while selected, so slaves can share it
        pins.miso_oe = enabled && !master && selected;
        if (!enabled) begin
            pins = '0;
        end
    end

    assign serial_control_reg = s_reg.ctl;
    assign rx_data = s_reg.rx;
    assign serial_status_reg = {s_reg.flags.done, s_reg.flags.collide,
                                s_reg.flags.fault, s_reg.flags.hold_full,
                                s_reg.flags.busy, 3'h0};

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_reset_disabled: assert property (
        @(posedge clk_sys)
        $fell(reset) |-> !serial_control_reg[CTL_ENABLE_POS])
        else $error("port enabled straight after reset");
    chk_pins_released: assert property (
        @(posedge clk_sys) disable iff (reset)
        !enabled |-> !pins.sclk_oe && !pins.mosi_oe && !pins.miso_oe)
        else $error("pin driven while disabled");
    chk_mode_change: assert property (
        @(posedge clk_sys) disable iff (reset)
        (enabled && master && sel_used && !ssn_s) |=>
        !enabled && !master && serial_status_reg[ST_DONE_POS])
        else $error("low select did not force slave");
    chk_busy_tracks: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(serial_status_reg[ST_BUSY_POS]) |->
        $past(s_reg.tx_holding_full) || $past(selected))
        else $error("busy rose with no transfer asked for");
    chk_collide_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        (tx_we && s_reg.tx_holding_full && s_reg.state != SMSP_IDLE) |=>
        serial_status_reg[ST_COLLIDE_POS])
        else $error("collision not flagged");
    chk_done_after_last: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_reg.state == SMSP_LAST &&
        !(enabled && master && sel_used && !ssn_s) |=>
        serial_status_reg[ST_DONE_POS] && !serial_status_reg[ST_BUSY_POS])
        else $error("done missing after last bit");
    chk_clock_dir: assert property (
        @(posedge clk_sys) disable iff (reset)
        pins.sclk_oe |-> master && enabled)
        else $error("clock driven outside master mode");
    chk_slave_select: assert property (
        @(posedge clk_sys) disable iff (reset)
        pins.miso_oe |-> !master && selected)
        else $error("slave drives miso unselected");
    chk_hold_flag: assert property (
        @(posedge clk_sys) disable iff (reset)
        (tx_we && !s_reg.tx_holding_full) |=>
        serial_status_reg[ST_HOLD_FULL_POS])
        else $error("holding flag not set by write");
endmodule

// ===== pkg/smsp_pkg.sv
// shared constants and carriers for the serial master/slave port
package smsp_pkg;
    // control bit positions
    localparam int CTL_SEL_IGNORE_POS = 7;
    localparam int CTL_ENABLE_POS     = 6;
    localparam int CTL_MASTER_POS     = 4;
    // status bit positions
    localparam int ST_DONE_POS        = 7;
    localparam int ST_COLLIDE_POS     = 6;
    localparam int ST_FAULT_POS       = 5;
    localparam int ST_HOLD_FULL_POS   = 4;
    localparam int ST_BUSY_POS        = 3;
    localparam logic [7:0] CTL_RESET  = 8'h00;
    // timing: master bit rate and slave clock limit at the reference clock
    localparam int REF_CLK_MHZ        = 48;
    localparam int MASTER_MBPS        = 24;
    localparam int SLAVE_CLK_MHZ      = 12;
    localparam int SYS_CLK_MHZ        = 125;
    // master half period in system cycles, at least one
    localparam int HALF_CYCLES_CALC   = SYS_CLK_MHZ / (2 * MASTER_MBPS);
    localparam int HALF_CYCLES        =
        (HALF_CYCLES_CALC < 1) ? 1 : HALF_CYCLES_CALC;
    localparam int DATA_BITS          = 8;

    typedef enum logic [1:0] {
        SMSP_IDLE  = 2'b00,
        SMSP_SHIFT = 2'b01,
        SMSP_LAST  = 2'b11
    } smsp_state_t;

    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } smsp_pins_t;

    typedef struct packed {
        logic done;
        logic collide;
        logic fault;
        logic hold_full;
        logic busy;
    } smsp_flags_t;
endpackage

// ===== hw/smsp_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module smsp_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("smsp_sync width must be at least one");
        end
    end

    // meta_reg feeds only the second stage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ===== test/smsp_far_end.sv
// far-side model: slave to our master, master to our slave
`timescale 1ns/1ps
module smsp_far_end (
    input  wire logic       dut_sclk,
    input  wire logic       mosi_line,
    input  wire logic       miso_line,
    input  wire logic [7:0] slave_byte,
    output logic            sclk,
    output logic            mosi,
    output logic            miso,
    output logic            select_n,
    output logic [7:0]      rx_byte,
    output int              rx_count
);
    int         s_bits = 0;
    logic [7:0] s_rx   = 8'h00;
    initial begin
        sclk     = 1'b0;
        mosi     = 1'b0;
        miso     = 1'b0;
        select_n = 1'b1;
        rx_byte  = 8'h00;
        rx_count = 0;
    end
    always @(posedge dut_sclk) begin
        s_rx = {s_rx[6:0], mosi_line};
        s_bits++;
        if (s_bits == 8) begin
            s_bits = 0;
            rx_byte = s_rx;
            rx_count++;
        end
    end
    // bytes may follow with no gap, so the next msb is readied at once
    always @(negedge dut_sclk) begin
        miso = slave_byte[3'h7 - s_bits[2:0]];
    end
    always @(slave_byte) begin
        if (s_bits == 0) begin
            miso = slave_byte[7];
        end
    end
    ////////////////////////////////////////////////////////////////////
    // master side: 160 ns bit time, clock stands still between frames
    task automatic frame(input logic [7:0] m, input logic sel);
        logic [7:0] got;
        got      = 8'h00;
        #3;
        select_n = ~sel;
        mosi     = m[7];
        #80;
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            got  = {got[6:0], miso_line};
            #80;
            sclk = 1'b0;
            if (i > 0) begin
                mosi = m[i-1];
            end
            #80;
        end
        select_n = 1'b1;
        mosi     = ~m[0];
        if (sel) begin
            rx_byte = got;
        end
    endtask
endmodule

// ===== test/test_spi_master_slave_port.sv
// self-checking bench for the serial master/slave port
`timescale 1ns/1ps
module test_spi_master_slave_port
    import smsp_pkg::*;
;
    logic        clk_sys, reset, ctl_we, tx_we, status_clr, sel_out;
    logic        sclk_p, mosi_p, miso_p, ssn;
    logic [7:0]  ctl_wdata, tx_wdata, ctl, rx, st, sbyte, far_rx, tb, mb, oe;
    logic [31:0] seed;
    int          far_cnt;
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    smsp_pins_t  pins;
    wire sclk_w = pins.sclk_oe ? pins.sclk_o : sclk_p;
    wire mosi_w = pins.mosi_oe ? pins.mosi_o : mosi_p;
    wire miso_w = pins.miso_oe ? pins.miso_o : miso_p;
    smsp_port smsp_port_i (
        .clk_sys(clk_sys), .reset(reset), .ctl_wdata(ctl_wdata),
        .ctl_we(ctl_we), .serial_control_reg(ctl), .tx_wdata(tx_wdata),
        .tx_we(tx_we), .rx_data(rx), .serial_status_reg(st),
        .status_clr(status_clr), .status_clr_mask(ctl_wdata),
        .select_pin_is_output(sel_out), .sclk_i(sclk_w), .mosi_i(mosi_w),
        .miso_i(miso_w), .slave_select_n(ssn), .pins(pins)
    );
    smsp_far_end smsp_far_end_i (
        .dut_sclk(pins.sclk_oe & pins.sclk_o), .mosi_line(mosi_w),
        .miso_line(miso_w), .slave_byte(sbyte), .sclk(sclk_p),
        .mosi(mosi_p), .miso(miso_p), .select_n(ssn), .rx_byte(far_rx),
        .rx_count(far_cnt)
    );
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x  = s ^ (s << 13);
        x  = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    // f = ignore, enable, master
    function automatic logic [7:0] ctl_word(input logic [2:0] f);
        ctl_word                     = 8'h00;
        ctl_word[CTL_SEL_IGNORE_POS] = f[2];
        ctl_word[CTL_ENABLE_POS]     = f[1];
        ctl_word[CTL_MASTER_POS]     = f[0];
    endfunction
    // f = done, collide, fault, holding full, busy
    function automatic logic [7:0] st_word(input logic [4:0] f);
        st_word                   = 8'h00;
        st_word[ST_DONE_POS]      = f[4];
        st_word[ST_COLLIDE_POS]   = f[3];
        st_word[ST_FAULT_POS]     = f[2];
        st_word[ST_HOLD_FULL_POS] = f[1];
        st_word[ST_BUSY_POS]      = f[0];
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // k: 0 control, 1 transmit, 2 clear status flags
    task automatic wr(input int k, input logic [7:0] v);
        @(negedge clk_sys);
        ctl_wdata  = v;
        tx_wdata   = v;
        ctl_we     = (k == 0);
        tx_we      = (k == 1);
        status_clr = (k == 2);
        @(negedge clk_sys);
        ctl_we     = 1'b0;
        tx_we      = 1'b0;
        status_clr = 1'b0;
    endtask
    task automatic wait_far(input int n);
        int k;
        k = 0;
        while (far_cnt < n && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic close_out();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {ctl_we, tx_we, status_clr, sel_out} = 4'h0;
        {ctl_wdata, tx_wdata, sbyte} = 24'h000000;
        seed = 32'h17;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check(ctl, 8'h00);
        check({2'h0, pins}, 8'h00);
        check(st, 8'h00);
        wr(0, ctl_word(3'h3));
        for (int i = 0; i < 5; i++) begin
            seed  = xs(seed);
            sbyte = seed[15:8];
            tb    = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0];
            wr(1, tb);
            check(st, st_word(5'h02));
            @(negedge clk_sys);
            oe = {5'h00, pins.sclk_oe, pins.mosi_oe, st[ST_BUSY_POS]};
            check(oe, 8'h07);
            wait_far(far_cnt + 1);
            check(rx, sbyte);
            check(far_rx, tb);
            check(st, st_word(5'h10));
            wr(2, 8'he0);
        end
        // second byte waits in holding, a third write is refused
        wr(1, seed[23:16]);
        wr(1, seed[31:24]);
        check(st, st_word(5'h03));
        wr(1, 8'h3c);
        check(st, st_word(5'h0b));
        wait_far(far_cnt + 2);
        check(far_rx, seed[31:24]);
        check(st, st_word(5'h18));
        wr(2, 8'he0);
        wr(0, ctl_word(3'h2));
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            tb   = seed[7:0];
            mb   = seed[15:8];
            wr(1, tb);
            fork
                smsp_far_end_i.frame(mb, 1'b1);
                begin
                    repeat (60) @(negedge clk_sys);
                    oe = {5'h00, pins.sclk_oe, pins.mosi_oe, pins.miso_oe};
                    check(oe, 8'h01);
                end
            join
            repeat (6) @(negedge clk_sys);
            check(rx, mb);
            check(far_rx, tb);
            check(st, st_word(5'h10));
            wr(2, 8'he0);
        end
        smsp_far_end_i.frame(8'h81, 1'b0);
        repeat (6) @(negedge clk_sys);
        check(rx, mb);
        check(st, 8'h00);
        // peer forces us to slave unless the select is ignored
        for (int i = 0; i < 3; i++) begin
            sel_out = (i == 1);
            wr(0, ctl_word({i == 2, 2'h3}));
            smsp_far_end_i.frame(8'h5a, 1'b1);
            repeat (6) @(negedge clk_sys);
            if (i == 0) begin
                check(ctl, 8'h00);
                check(st, st_word(5'h14));
                check({2'h0, pins}, 8'h00);
            end else begin
                check(ctl, ctl_word({i == 2, 2'h3}));
                check(st, 8'h00);
            end
            wr(2, 8'he0);
        end
        close_out();
    end
endmodule
